// *** src/uart_pin_consts.svh ***
// constants for the serial pin block: register offsets, fields, resets, timing
// assumes inclusion by bare name from design files
`ifndef UART_PIN_CONSTS_SVH
`define UART_PIN_CONSTS_SVH
`define OFS_CTRL        12'h000
`define OFS_STATUS      12'h004
`define OFS_TXDATA      12'h008
`define OFS_RXDATA      12'h00C
`define OFS_BAUD        12'h010
`define OFS_RTSLVL      12'h014
`define CTRL_TX_EN      0
`define CTRL_RX_EN      1
`define CTRL_LOOP       2
`define CTRL_AUTO_RTS   3
`define CTRL_RTS_MAN    4
`define CTRL_PWR_DOWN   5
`define CTRL_RESET      32'h0000_0000
`define BAUD_RESET      16'h001A
`define RTSLVL_RESET    4'h6
`define QUEUE_DEPTH     8
`define QUEUE_AW        3
`define CLK_PER_NS      40
`endif

// *** src/uart_pin_pkg.sv ***
// types shared by the serial pin block
// assumes nothing beyond a SystemVerilog compiler
package uart_pin_pkg;
	typedef logic [7:0] char_t;
	typedef enum logic [1:0] {
		TX_IDLE  = 2'b00,
		TX_START = 2'b01,
		TX_DATA  = 2'b11,
		TX_STOP  = 2'b10
	} tx_state_e;
	typedef enum logic [1:0] {
		RX_IDLE  = 2'b00,
		RX_START = 2'b01,
		RX_DATA  = 2'b11,
		RX_STOP  = 2'b10
	} rx_state_e;
endpackage : uart_pin_pkg

// *** src/bit_clk_if.sv ***
// interface carrying the bit-rate strobes from the divider to the serial logic
// assumes one clock domain, pclk
`timescale 1ns/1ps
interface bit_clk_if;
	logic        run;
	logic [15:0] divisor;
	logic        fall_tick;
	logic        mid_tick;
	logic        clk_running;
	modport gen (input run, input divisor, output fall_tick, output mid_tick, output clk_running);
	modport use_ (output run, output divisor, input fall_tick, input mid_tick, input clk_running);
endinterface : bit_clk_if

// *** src/bit_clk_gen.sv ***
// serial clock source: divider of pclk giving a falling-edge strobe and a
// mid-period strobe; stops when run is low
// assumes divisor of at least 2
`timescale 1ns/1ps
`include "uart_pin_consts.svh"
module bit_clk_gen import uart_pin_pkg::*; (
	// system
	input  wire logic pclk,
	input  wire logic presetn,
	// strobes
	bit_clk_if.gen    bc
);
	logic [15:0] cnt_r;
	logic        run_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_r <= 1'b0;
		end else begin
			run_r <= bc.run;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= 16'h0000;
		end else if (!bc.run || cnt_r >= bc.divisor - 16'h0001) begin
			cnt_r <= 16'h0000;
		end else begin
			cnt_r <= cnt_r + 16'h0001;
		end
	end

	// counter wrap marks the falling edge of the serial clock
	assign bc.fall_tick   = run_r && bc.run && (cnt_r == bc.divisor - 16'h0001);
	assign bc.mid_tick    = run_r && bc.run && (cnt_r == {1'b0, bc.divisor[15:1]});
	assign bc.clk_running = run_r;
endmodule : bit_clk_gen

// *** src/uart_pin_top.sv ***
// serial transmitter/receiver pin behaviour with APB register access
// assumes pins synchronous to pclk, 8N1 framing, one bit-clock period per bit
//
// Contract
// - transmit pin idles high when disabled, empty, or in loopback.
// - transmitted character goes out least significant bit first.
// - transmit pin changes at the falling edge of the serial clock, except when transmit is disabled or loopback is switched.
// - first received data bit becomes the least significant bit.
// - in power-down, any receive-line change restarts the channel clock.
// - remote grants with clear-to-send; transmission starts only when granted.
// - request-to-send can be driven by hardware without software toggling.
// - auto request-to-send follows receive queue fill against a threshold.
`timescale 1ns/1ps
`include "uart_pin_consts.svh"
module uart_pin_top import uart_pin_pkg::*; (
	// apb
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// serial pins
	input  wire logic        serial_rx_in,
	input  wire logic        clear_to_send_in,
	output logic             serial_tx_out,
	output logic             request_to_send_out
);
	bit_clk_if bc ();
	bit_clk_gen u_bclk (.pclk(pclk), .presetn(presetn), .bc(bc));

	logic [5:0]  ctrl_r;
	logic [15:0] baud_r;
	logic [3:0]  rts_lvl_r;
	char_t       tx_hold_r;
	logic        tx_full_r;
	tx_state_e   tx_st_r;
	char_t       tx_sh_r;
	logic [2:0]  tx_cnt_r;
	logic        tx_line_r;
	rx_state_e   rx_st_r;
	char_t       rx_sh_r;
	logic [2:0]  rx_cnt_r;
	logic        rx_prev_r;
	logic        wake_r;
	logic        overrun_r;
	logic        frame_err_r;
	char_t       queue_r [`QUEUE_DEPTH];
	logic [`QUEUE_AW-1:0] wp_r;
	logic [`QUEUE_AW-1:0] rp_r;
	logic [`QUEUE_AW:0]   fill_r;

	logic wr_acc;
	logic rd_acc;
	logic rx_line;
	logic rx_push;
	logic rx_pop;
	logic tx_load;
	logic ext_line;

	assign wr_acc  = psel && penable && pwrite;
	assign rd_acc  = psel && penable && !pwrite;
	// loopback takes the internal stream, external line ignored
	assign ext_line = ctrl_r[`CTRL_LOOP] ? tx_line_r : serial_rx_in;
	assign rx_line  = ext_line;
	assign rx_pop   = rd_acc && paddr == `OFS_RXDATA && fill_r != '0;
	assign tx_load  = tx_st_r == TX_IDLE && tx_full_r && ctrl_r[`CTRL_TX_EN]
		&& clear_to_send_in && bc.fall_tick;

	// channel clock runs while enabled, unless powered down and not woken
	assign bc.run     = (ctrl_r[`CTRL_TX_EN] || ctrl_r[`CTRL_RX_EN])
		&& (!ctrl_r[`CTRL_PWR_DOWN] || wake_r);
	assign bc.divisor = baud_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r    <= 6'h00;
			baud_r    <= `BAUD_RESET;
			rts_lvl_r <= `RTSLVL_RESET;
		end else if (wr_acc) begin
			case (paddr)
				`OFS_CTRL:   ctrl_r    <= pwdata[5:0];
				`OFS_BAUD:   baud_r    <= (pwdata[15:0] < 16'h0002) ? 16'h0002 : pwdata[15:0];
				`OFS_RTSLVL: rts_lvl_r <= pwdata[3:0];
				default:     ;
			endcase
		end
	end

	// transmit holding register: software fills, shifter empties
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_hold_r <= 8'h00;
			tx_full_r <= 1'b0;
		end else if (wr_acc && paddr == `OFS_TXDATA && !tx_full_r) begin
			tx_hold_r <= pwdata[7:0];
			tx_full_r <= 1'b1;
		end else if (tx_load) begin
			tx_full_r <= 1'b0;
		end
	end

	// transmit shifter; every change lands on the serial clock falling edge, except the forced return to idle when transmit is disabled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_st_r   <= TX_IDLE;
			tx_sh_r   <= 8'h00;
			tx_cnt_r  <= 3'h0;
			tx_line_r <= 1'b1;
		end else if (!ctrl_r[`CTRL_TX_EN]) begin
			tx_st_r   <= TX_IDLE;
			tx_line_r <= 1'b1;
		end else if (bc.fall_tick) begin
			case (tx_st_r)
				TX_IDLE: begin
					tx_line_r <= 1'b1;
					if (tx_load) begin
						tx_sh_r   <= tx_hold_r;
						tx_line_r <= 1'b0;
						tx_st_r   <= TX_START;
					end
				end
				TX_START: begin
					tx_line_r <= tx_sh_r[0];
					tx_sh_r   <= {1'b0, tx_sh_r[7:1]};
					tx_cnt_r  <= 3'h0;
					tx_st_r   <= TX_DATA;
				end
				TX_DATA: begin
					if (tx_cnt_r == 3'h7) begin
						tx_line_r <= 1'b1;
						tx_st_r   <= TX_STOP;
					end else begin
						tx_line_r <= tx_sh_r[0];
						tx_sh_r   <= {1'b0, tx_sh_r[7:1]};
						tx_cnt_r  <= tx_cnt_r + 3'h1;
					end
				end
				TX_STOP: begin
					tx_line_r <= 1'b1;
					tx_st_r   <= TX_IDLE;
				end
				default: tx_st_r <= TX_IDLE;
			endcase
		end
	end

	// external pin held at mark in loopback
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			serial_tx_out <= 1'b1;
		end else begin
			serial_tx_out <= ctrl_r[`CTRL_LOOP] ? 1'b1 : tx_line_r;
		end
	end

	// wake on any receive-line change while powered down
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_prev_r <= 1'b1;
			wake_r    <= 1'b0;
		end else begin
			rx_prev_r <= serial_rx_in;
			if (!ctrl_r[`CTRL_PWR_DOWN]) begin
				wake_r <= 1'b0;
			end else if (serial_rx_in != rx_prev_r) begin
				wake_r <= 1'b1;
			end
		end
	end

	// receiver samples each bit at the middle of its period
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_st_r     <= RX_IDLE;
			rx_sh_r     <= 8'h00;
			rx_cnt_r    <= 3'h0;
			frame_err_r <= 1'b0;
		end else if (!ctrl_r[`CTRL_RX_EN]) begin
			rx_st_r <= RX_IDLE;
		end else begin
			if (rd_acc && paddr == `OFS_STATUS) begin
				frame_err_r <= 1'b0;
			end
			// idle looks every cycle so the next mid tick lands inside the start bit
			if (bc.mid_tick || rx_st_r == RX_IDLE) begin
				case (rx_st_r)
					RX_IDLE: begin
						if (!rx_line) begin
							rx_st_r  <= bc.mid_tick ? RX_DATA : RX_START;
							rx_cnt_r <= 3'h0;
						end
					end
					RX_START: begin
						rx_st_r  <= rx_line ? RX_IDLE : RX_DATA;
						rx_cnt_r <= 3'h0;
					end
					RX_DATA: begin
						rx_sh_r  <= {rx_line, rx_sh_r[7:1]};
						rx_cnt_r <= rx_cnt_r + 3'h1;
						if (rx_cnt_r == 3'h7) rx_st_r <= RX_STOP;
					end
					RX_STOP: begin
						if (!rx_line) frame_err_r <= 1'b1;
						rx_st_r <= RX_IDLE;
					end
					default: rx_st_r <= RX_IDLE;
				endcase
			end
		end
	end

	assign rx_push = ctrl_r[`CTRL_RX_EN] && bc.mid_tick && rx_st_r == RX_STOP && rx_line;

	// storage carries no reset; only pointers, fill count and overrun flag need one
	always_ff @(posedge pclk) begin
		if (rx_push && fill_r != (`QUEUE_AW+1)'(`QUEUE_DEPTH)) begin
			queue_r[wp_r] <= rx_sh_r;
		end
	end

	// receive queue in flip-flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wp_r      <= '0;
			rp_r      <= '0;
			fill_r    <= '0;
			overrun_r <= 1'b0;
		end else begin
			if (rx_push && fill_r != (`QUEUE_AW+1)'(`QUEUE_DEPTH)) begin
				wp_r <= wp_r + 1'b1;
			end
			if (rx_pop) rp_r <= rp_r + 1'b1;
			fill_r <= fill_r + (`QUEUE_AW+1)'(rx_push && fill_r != (`QUEUE_AW+1)'(`QUEUE_DEPTH))
				- (`QUEUE_AW+1)'(rx_pop);
			if (rx_push && fill_r == (`QUEUE_AW+1)'(`QUEUE_DEPTH)) begin
				overrun_r <= 1'b1;
			end else if (rd_acc && paddr == `OFS_STATUS) begin
				overrun_r <= 1'b0;
			end
		end
	end

	// request-to-send: manual level or queue-level throttle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			request_to_send_out <= 1'b0;
		end else if (ctrl_r[`CTRL_AUTO_RTS]) begin
			request_to_send_out <= {1'b0, fill_r} < {1'b0, rts_lvl_r};
		end else begin
			request_to_send_out <= ctrl_r[`CTRL_RTS_MAN];
		end
	end

	// apb answers in the access cycle with no wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && paddr > `OFS_RTSLVL;
			prdata  <= 32'h0000_0000;
			if (psel && !penable && !pwrite) begin
				case (paddr)
					`OFS_CTRL:   prdata <= {26'h0, ctrl_r};
					`OFS_STATUS: prdata <= {20'h0, bc.clk_running, wake_r, frame_err_r, overrun_r,
						fill_r, tx_st_r != TX_IDLE, tx_full_r, clear_to_send_in, request_to_send_out};
					`OFS_RXDATA: prdata <= {24'h0, queue_r[rp_r]};
					`OFS_BAUD:   prdata <= {16'h0, baud_r};
					`OFS_RTSLVL: prdata <= {28'h0, rts_lvl_r};
					default:     prdata <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule : uart_pin_top

// *** dv/uart_pin_monitor.sv ***
// assertion checker for uart_pin_top, bound to its ports
// assumes one pclk domain and asynchronous active-low presetn
`timescale 1ns/1ps
`include "uart_pin_consts.svh"
module uart_pin_monitor (
	// apb
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// serial pins
	input wire logic        serial_rx_in,
	input wire logic        clear_to_send_in,
	input wire logic        serial_tx_out,
	input wire logic        request_to_send_out
);
	logic [31:0] ctrl_r;
	logic [15:0] baud_r;
	logic [19:0] high_r;
	wire         wr_done = psel && penable && pready && pwrite;
	// line at mark for over ten bit times counts as idle
	wire         tx_idle = high_r > {4'h0, baud_r} * 20'hA;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= `CTRL_RESET;
			baud_r <= `BAUD_RESET;
		end else if (wr_done && paddr == `OFS_CTRL) begin
			ctrl_r <= pwdata;
		end else if (wr_done && paddr == `OFS_BAUD) begin
			baud_r <= pwdata[15:0];
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) high_r <= 20'h0;
		else if (!serial_tx_out) high_r <= 20'h0;
		else if (high_r != 20'hF_FFFF) high_r <= high_r + 20'h1;
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence setup_s; psel && !penable; endsequence
	sequence access_s; psel && penable && pready; endsequence
	ready_setup_a: assert property (setup_s |=> access_s) else $error("no ready after setup");
	ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
	bad_addr_a: assert property (access_s ##0 (paddr > `OFS_RTSLVL) |-> pslverr) else $error("no slave error");
	err_alone_a: assert property (!pready |-> !pslverr) else $error("error without ready");
	bad_read_a: assert property (access_s ##0 (!pwrite && paddr > `OFS_RTSLVL) |-> prdata == 32'h0)
		else $error("unmapped read data");
	tx_mark_a: assert property (tx_idle && (!ctrl_r[`CTRL_TX_EN] || ctrl_r[`CTRL_LOOP]) |=> serial_tx_out)
		else $error("tx left mark");
	cts_hold_a: assert property (tx_idle && !$past(clear_to_send_in) && !$past(clear_to_send_in, 2)
		|=> serial_tx_out) else $error("start without cts");
	rts_man_a: assert property (!ctrl_r[`CTRL_AUTO_RTS] && ctrl_r == $past(ctrl_r, 3)
		|-> request_to_send_out == ctrl_r[`CTRL_RTS_MAN]) else $error("manual rts");
endmodule : uart_pin_monitor
bind uart_pin_top uart_pin_monitor uart_pin_monitor_i (.*);

// *** dv/serial_peer.sv ***
// remote serial device: sends characters on demand, collects what it hears
// assumes 8N1 framing, bit_len pclk cycles per bit
`timescale 1ns/1ps
module serial_peer (
	// clock
	input wire logic        pclk,
	// serial lines
	input wire logic        line_in,
	output logic            line_out,
	// bit time
	input wire logic [15:0] bit_len
);
	logic [7:0] got [$];
	logic [7:0] shift_r;
	initial line_out = 1'b1;
	// start bit, data low bit first, stop bit; line then rests at mark
	task automatic send(input logic [7:0] d);
		for (int i = 0; i < 10; i++) begin
			line_out <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : d[i - 1];
			repeat (bit_len) @(posedge pclk);
		end
	endtask : send
	// samples near the middle of each bit
	always begin
		@(negedge line_in);
		repeat (bit_len / 2) @(posedge pclk);
		for (int i = 0; i < 8; i++) begin
			repeat (bit_len) @(posedge pclk);
			shift_r[i] = line_in;
		end
		got.push_back(shift_r);
	end
endmodule : serial_peer

// *** dv/testbench.sv ***
// self-checking bench: apb master, serial peer, register table and pin cases
// assumes uart_pin_top, serial_peer and the bound checker
`timescale 1ns/1ps
`include "uart_pin_consts.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fails++; \
	$display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module testbench;
	typedef struct packed { logic [11:0] a; logic [31:0] d; logic [31:0] e; } row_s;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0;
	logic        cts = 1'b0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        rx_line;
	logic        tx_line;
	logic        rts;
	logic [31:0] rd;
	logic        err;
	int          fails = 0;
	int          samples_checked = 0;
	int          cycles = 0;
	row_s        rows [4] = '{'{`OFS_BAUD, 32'h8, 32'h8}, '{`OFS_RTSLVL, 32'h3, 32'h3},
		'{`OFS_CTRL, 32'h10, 32'h10}, '{12'h18, 32'hFFFF, 32'h0}};
	uart_pin_top uart_pin_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_rx_in(rx_line),
		.clear_to_send_in(cts), .serial_tx_out(tx_line), .request_to_send_out(rts));
	serial_peer serial_peer_i (.pclk(pclk), .line_in(tx_line), .line_out(rx_line), .bit_len(16'h8));
	always #20 pclk = ~pclk;
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			results();
		end
	end
	task automatic results();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : results
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic pause(input int n);
		repeat (n) @(posedge pclk);
	endtask : pause
	initial begin
		pause(10);
		presetn <= 1'b1;
		`CHK({tx_line, rts}, 2'b10)
		apb(1'b0, `OFS_CTRL, 32'h0);
		`CHK(rd, `CTRL_RESET)
		apb(1'b0, `OFS_BAUD, 32'h0);
		`CHK(rd[15:0], `BAUD_RESET)
		apb(1'b0, `OFS_RTSLVL, 32'h0);
		`CHK(rd[3:0], `RTSLVL_RESET)
		$display("reset test done");
		foreach (rows[i]) begin
			apb(1'b1, rows[i].a, rows[i].d);
			apb(1'b0, rows[i].a, 32'h0);
			`CHK({err, rd}, {rows[i].a > `OFS_RTSLVL, rows[i].e})
		end
		`CHK(rts, 1'b1)
		$display("register test done");
		apb(1'b1, `OFS_CTRL, 32'h3);
		apb(1'b1, `OFS_TXDATA, 32'hA5);
		pause(200);
		`CHK(tx_line, 1'b1)
		cts <= 1'b1;
		for (int k = 0; k < 300 && serial_peer_i.got.size() == 0; k++) @(posedge pclk);
		`CHK(serial_peer_i.got[0], 8'hA5)
		$display("transmit test done");
		serial_peer_i.send(8'h3C);
		pause(4);
		apb(1'b0, `OFS_RXDATA, 32'h0);
		`CHK(rd[7:0], 8'h3C)
		apb(1'b1, `OFS_RTSLVL, 32'h2);
		apb(1'b1, `OFS_CTRL, 32'hB);
		pause(3);
		`CHK(rts, 1'b1)
		serial_peer_i.send(8'h11);
		serial_peer_i.send(8'h22);
		pause(4);
		`CHK(rts, 1'b0)
		apb(1'b0, `OFS_RXDATA, 32'h0);
		pause(3);
		`CHK({rts, rd[7:0]}, 9'h111)
		apb(1'b0, `OFS_RXDATA, 32'h0);
		`CHK(rd[7:0], 8'h22)
		$display("flow test done");
		apb(1'b1, `OFS_CTRL, 32'h7);
		apb(1'b1, `OFS_TXDATA, 32'h96);
		pause(120);
		apb(1'b0, `OFS_RXDATA, 32'h0);
		`CHK({tx_line, rd[7:0]}, 9'h196)
		$display("loopback test done");
		apb(1'b1, `OFS_CTRL, 32'h22);
		apb(1'b0, `OFS_STATUS, 32'h0);
		`CHK(rd[11], 1'b0)
		serial_peer_i.send(8'hF0);
		apb(1'b0, `OFS_STATUS, 32'h0);
		`CHK(rd[11:10], 2'b11)
		$display("wake test done");
		presetn <= 1'b0;
		pause(4);
		presetn <= 1'b1;
		pause(1);
		`CHK({tx_line, rts}, 2'b10)
		apb(1'b0, `OFS_STATUS, 32'h0);
		`CHK(rd, 32'h0000_0002)
		apb(1'b0, `OFS_CTRL, 32'h0);
		`CHK(rd, `CTRL_RESET)
		$display("mid-run reset test done");
		results();
	end
endmodule : testbench
